/* design/odb_pkg.sv */
// Shared constants, register map and carrier types of the output divider bank.
// Assumes one 10 MHz APB clock; each enabled clock cycle is one VCO period.
package odb_pkg;
  // Bank shape and field widths.
  localparam int N_IOD = 4;
  localparam int N_FOD = 3;
  localparam int N_BANK = 7;
  localparam int SSC_FODS = 2;
  localparam int IOD_W = 25;
  localparam int FI_W = 8;
  localparam int NUM_W = 34;
  localparam int S2_W = 17;
  localparam int FCW_W = 29;
  localparam int IPH_W = 16;
  localparam int FPH_W = 11;
  localparam int AMP_W = 5;
  localparam int RATE_W = 16;
  localparam int NP_W = 8;
  // Phase range in time, and the VCO it is counted against.
  localparam int PH_RANGE_PS = 20000;
  localparam int VCO_MIN_MHZ = 9500;
  localparam int VCO_MAX_MHZ = 10700;
  localparam int PH_IMAX = PH_RANGE_PS * VCO_MAX_MHZ / 1000000;
  localparam int PH_QMAX = PH_RANGE_PS * 4 * VCO_MAX_MHZ / 1000000;
  // Limits and steps.
  localparam logic [AMP_W-1:0] AMP_MAX = 5'h1e;
  localparam logic [S2_W-1:0] S2_MIN = 17'h00002;
  localparam logic [NUM_W-1:0] NCO_SLEW = 34'h000000400;
  // Register byte offsets.
  localparam logic [7:0] A_GLB = 8'h00;
  localparam logic [7:0] A_FCW = 8'h04;
  localparam logic [7:0] A_IOD = 8'h10;
  localparam logic [7:0] A_FOD = 8'h40;
  localparam logic [7:0] A_BANK = 8'h70;
  localparam logic [7:0] IOD_SPAN = 8'h20;
  localparam logic [7:0] FOD_SPAN = 8'h30;
  localparam logic [7:0] BANK_SPAN = 8'h1c;
  // Field positions.
  localparam int GLB_MASK = 4;
  localparam int GLB_GO = 8;
  localparam int GLB_BUSY = 12;
  localparam int GLB_SSCA = 16;
  localparam int IOD_SR = 1;
  localparam int IOD_BUSY = 2;
  localparam int IOD_NP = 8;
  localparam int IOD_PH = 16;
  localparam int FOD_BYP = 8;
  localparam int FOD_SSC = 9;
  localparam int FOD_CTR = 10;
  localparam int FOD_AMP = 11;
  localparam int FOD_RATE = 16;
  localparam int FOD_NHI = 17;
  localparam int FOD_PH = 21;
  localparam int BK_SE = 3;
  localparam int BK_PEN = 4;
  localparam int BK_NEN = 5;
  localparam int BK_INV = 6;
  localparam int BK_EN = 7;
  // Source codes legal per bank, one bit per code, bank 6 first.
  localparam logic [N_BANK-1:0][7:0] BANK_OK = {8'hec, 8'hef, 8'hf4, 8'h70,
    8'h70, 8'h33, 8'h33};
  localparam logic [2:0] SRC_FRACTIONAL_DIVIDER_ZERO = 3'h4;
  localparam logic [2:0] SRC_CLKIN0 = 3'h7;
  typedef enum logic [4:0] {
    SS_IDLE = 5'b00001,
    SS_RISE = 5'b00010,
    SS_FALL = 5'b00100,
    SS_SINK = 5'b01000,
    SS_LIFT = 5'b10000
  } odb_ssc_e_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } odb_apb_t;
  typedef struct packed {
    logic clkin0;
    logic clkin1;
    logic xin;
  } odb_byp_t;
  typedef struct packed {
    logic [N_BANK-1:0] p;
    logic [N_BANK-1:0] n;
    logic [N_BANK-1:0] oe_p;
    logic [N_BANK-1:0] oe_n;
  } odb_pins_t;
  typedef struct packed {
    logic mode;
    logic ref_used;
    logic [FCW_W-1:0] frequency_control_word;
  } odb_dco_t;
endpackage

/* design/odb_bank.sv */
// Output divider bank: integer and fractional dividers, spread, phase
// stepping, NCO slewing, DCO word and bank source and pin pairing.
// Assumes pclk stands for the VCO clock; bypass clocks arrive asynchronously.
`timescale 1ns/1ns
// Function
// - Four integer dividers with 25-bit ratio.
// - New integer ratio takes effect at once.
// - Optional squelch gives gapped clock on change.
// - Sysref pulse mode sends counted pulses.
// - Partial sysref subset, independent divider phases.
// - Fractional first stage with edge delay correction.
// - Second 17-bit stage, ratio four to 2*max.
// - Second stage bypassable for fast outputs.
// - Spread only on fractional dividers zero, one.
// - Triangular spread, down or center.
// - Spread rate programmable, 30 to 63 kHz.
// - Amplitude in 0.05% steps to 1.5%.
// - Spread stop finishes current cycle first.
// - Fractional phase in quarter VCO steps.
// - Integer phase in whole VCO steps.
// - DCO 29-bit signed word to feedback.
// - DCO mode ignores reference clock inputs.
// - NCO numerator slews gradually, fixed denominator.
// - Pair splits into single-ended, phase or inverted.
// - Seven banks pick legal 3-bit sources.
// - Dividers run from the 9.5-10.7 GHz VCO.
module odb_bank (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire odb_pkg::odb_apb_t apb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire odb_pkg::odb_byp_t byp_in,
  output odb_pkg::odb_pins_t pins,
  output odb_pkg::odb_dco_t dco,
  output logic [odb_pkg::N_FOD-1:0][1:0] fod_delay
);
  import odb_pkg::*;

  typedef struct packed {
    odb_byp_t sy1;
    odb_byp_t sy2;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic dco_en;
    logic ref_used;
    logic [FCW_W-1:0] frequency_control_word;
    logic [N_IOD-1:0] sr_mask;
    logic [N_IOD-1:0][IOD_W-1:0] iratio;
    logic [N_IOD-1:0][IOD_W-1:0] icnt;
    logic [N_IOD-1:0] sqen;
    logic [N_IOD-1:0] srmode;
    logic [N_IOD-1:0] sq;
    logic [N_IOD-1:0] arm;
    logic [N_IOD-1:0] iclk;
    logic [N_IOD-1:0][NP_W-1:0] np;
    logic [N_IOD-1:0][NP_W-1:0] left;
    logic [N_IOD-1:0][IPH_W-1:0] iph;
    logic [N_FOD-1:0][FI_W-1:0] fint;
    logic [N_FOD-1:0][FI_W-1:0] cnt1;
    logic [N_FOD-1:0][FI_W-1:0] lim;
    logic [N_FOD-1:0] byp;
    logic [N_FOD-1:0] sscen;
    logic [N_FOD-1:0] ctr;
    logic [N_FOD-1:0] s2clk;
    logic [N_FOD-1:0] fclk;
    logic [N_FOD-1:0][AMP_W-1:0] amp;
    logic [N_FOD-1:0][RATE_W-1:0] rate;
    logic [N_FOD-1:0][RATE_W-1:0] rc;
    logic [N_FOD-1:0][NUM_W-1:0] tgt;
    logic [N_FOD-1:0][NUM_W-1:0] num;
    logic [N_FOD-1:0][NUM_W-1:0] acc;
    logic [N_FOD-1:0][S2_W-1:0] s2n;
    logic [N_FOD-1:0][S2_W-1:0] s2cnt;
    logic [N_FOD-1:0][FPH_W-1:0] fph;
    logic [N_FOD-1:0][1:0] q;
    logic [N_FOD-1:0][1:0] dly;
    logic [N_FOD-1:0][31:0] unit;
    logic [N_FOD-1:0][5:0] t;
    odb_ssc_e_t [N_FOD-1:0] st;
    logic [N_BANK-1:0][7:0] bank;
    odb_pins_t pins;
  } odb_state_t;

  localparam odb_state_t S_RST = '{st: '{default: SS_IDLE}, default: '0};

  odb_state_t s;
  odb_state_t next_s;
  logic wr;
  logic hit;
  logic [7:0] a;
  logic [7:0] oi;
  logic [7:0] of;
  logic [7:0] ob;
  logic [31:0] rd;
  logic [31:0] wd;
  logic hold;
  logic skip;
  logic end1;
  logic c;
  logic [AMP_W-1:0] amp_eff;
  logic [S2_W-1:0] s2_eff;
  logic signed [39:0] off;
  logic signed [39:0] e;
  logic [NUM_W-1:0] ne;
  logic [NUM_W:0] sum;
  logic [2:0] code;
  logic sc;
  logic ok;

  // One pass computes the whole next state; register writes come last so a
  // write always overrides the free-running update of the same cycle.
  always_comb begin
    next_s = s;
    wr = apb.psel & apb.penable & apb.pwrite & s.pready;
    a = apb.paddr;
    wd = apb.pwdata;
    oi = a - A_IOD;
    of = a - A_FOD;
    ob = a - A_BANK;
    rd = '0;
    hit = 1'b0;
    hold = 1'b0;
    skip = 1'b0;
    end1 = 1'b0;
    c = 1'b0;
    amp_eff = '0;
    s2_eff = '0;
    off = '0;
    e = '0;
    ne = '0;
    sum = '0;
    code = '0;
    sc = 1'b0;
    ok = 1'b0;
    // Bypass clocks are asynchronous, so they pass two flops first.
    next_s.sy1 = byp_in;
    next_s.sy2 = s.sy1;
    // Integer dividers, one VCO period per enabled cycle.
    for (int i = 0; i < N_IOD; i++) begin
      end1 = (s.icnt[i] >= s.iratio[i] - 25'h0000001);
      if (s.iratio[i] == '0) begin
        end1 = 1'b0;
      end else if ($signed(s.iph[i]) > 0) begin
        next_s.iph[i] = s.iph[i] - 16'h0001;
      end else if ($signed(s.iph[i]) < 0) begin
        next_s.iph[i] = s.iph[i] + 16'h0001;
        next_s.icnt[i] = end1 ? '0 : s.icnt[i] + 25'h0000002;
      end else begin
        next_s.icnt[i] = end1 ? '0 : s.icnt[i] + 25'h0000001;
      end
      if (end1 && $signed(s.iph[i]) <= 0) begin
        next_s.sq[i] = 1'b0;
        // Arming waits for a period end so each divider keeps its skew.
        if (s.left[i] != '0) begin
          next_s.left[i] = s.left[i] - 8'h01;
        end else if (s.arm[i]) begin
          next_s.left[i] = s.np[i];
          next_s.arm[i] = 1'b0;
        end
      end
    end
    // Fractional dividers: NCO slew, spread engine, two stages.
    for (int j = 0; j < N_FOD; j++) begin
      // Numerator walks to its target in bounded steps, never jumping.
      if (s.num[j] < s.tgt[j]) begin
        next_s.num[j] = (s.tgt[j] - s.num[j] > NCO_SLEW) ?
          s.num[j] + NCO_SLEW : s.tgt[j];
      end else if (s.num[j] > s.tgt[j]) begin
        next_s.num[j] = (s.num[j] - s.tgt[j] > NCO_SLEW) ?
          s.num[j] - NCO_SLEW : s.tgt[j];
      end
      amp_eff = (s.amp[j] > AMP_MAX) ? AMP_MAX : s.amp[j];
      sc = (s.rc[j] >= s.rate[j]);
      next_s.rc[j] = sc ? '0 : s.rc[j] + 16'h0001;
      if (j < SSC_FODS) begin
        // Leaving the profile only at its zero crossing ends a full cycle.
        unique case (s.st[j])
          SS_IDLE: begin
            next_s.t[j] = '0;
            if (s.sscen[j]) next_s.st[j] = SS_RISE;
          end
          SS_RISE: if (sc) begin
            if ($signed(s.t[j]) >= $signed({1'b0, amp_eff}))
              next_s.st[j] = SS_FALL;
            else
              next_s.t[j] = s.t[j] + 6'h01;
          end
          SS_FALL: if (sc) begin
            if (s.t[j] == '0)
              next_s.st[j] = s.ctr[j] ? SS_SINK :
                (s.sscen[j] ? SS_RISE : SS_IDLE);
            else
              next_s.t[j] = s.t[j] - 6'h01;
          end
          SS_SINK: if (sc) begin
            if ($signed(s.t[j]) <= -$signed({1'b0, amp_eff}))
              next_s.st[j] = SS_LIFT;
            else
              next_s.t[j] = s.t[j] - 6'h01;
          end
          SS_LIFT: if (sc) begin
            if (s.t[j] == '0)
              next_s.st[j] = s.sscen[j] ? SS_RISE : SS_IDLE;
            else
              next_s.t[j] = s.t[j] + 6'h01;
          end
          default: next_s.st[j] = SS_IDLE;
        endcase
      end
      // A positive step lengthens the ratio, which is the down side.
      off = 40'($signed(s.t[j])) * 40'($signed({1'b0, s.unit[j]}));
      e = $signed({6'h00, s.num[j]}) + off;
      if (e < 0) ne = '0;
      else if (e[39:NUM_W] != '0) ne = '1;
      else ne = e[NUM_W-1:0];
      // Quarter steps ride the edge delay line; a full wrap moves a count.
      hold = 1'b0;
      skip = 1'b0;
      if ($signed(s.fph[j]) > 0) begin
        next_s.fph[j] = s.fph[j] - 11'h001;
        next_s.q[j] = s.q[j] + 2'h1;
        hold = (s.q[j] == 2'h3);
      end else if ($signed(s.fph[j]) < 0) begin
        next_s.fph[j] = s.fph[j] + 11'h001;
        next_s.q[j] = s.q[j] - 2'h1;
        skip = (s.q[j] == 2'h0);
      end
      end1 = (s.cnt1[j] >= s.lim[j]) || (skip && s.cnt1[j] + 8'h01 >= s.lim[j]);
      if (s.fint[j] >= 8'h02 && !hold) begin
        next_s.cnt1[j] = end1 ? '0 : s.cnt1[j] + (skip ? 8'h02 : 8'h01);
        if (end1) begin
          sum = {1'b0, s.acc[j]} + {1'b0, ne};
          next_s.acc[j] = sum[NUM_W-1:0];
          next_s.lim[j] = s.fint[j] - 8'h01 + {7'h00, sum[NUM_W]};
          s2_eff = (s.s2n[j] < S2_MIN) ? S2_MIN : s.s2n[j];
          if (s.s2cnt[j] >= s2_eff - 17'h00001) begin
            next_s.s2cnt[j] = '0;
            next_s.s2clk[j] = ~s.s2clk[j];
          end else begin
            next_s.s2cnt[j] = s.s2cnt[j] + 17'h00001;
          end
        end
      end
      next_s.dly[j] = next_s.q[j] + next_s.acc[j][NUM_W-1:NUM_W-2];
    end
    // Register access: one wait state, then the answer.
    if (a == A_GLB) begin
      hit = 1'b1;
      rd[0] = s.dco_en;
      rd[GLB_MASK +: N_IOD] = s.sr_mask;
      rd[GLB_BUSY +: N_IOD] = s.arm | s.srmode;
      for (int k = 0; k < N_FOD; k++) rd[GLB_SSCA + k] = (s.st[k] != SS_IDLE);
      if (wr) begin
        next_s.dco_en = wd[0];
        next_s.sr_mask = wd[GLB_MASK +: N_IOD];
        if (wd[GLB_GO])
          next_s.arm = s.arm | (wd[GLB_MASK +: N_IOD] & s.srmode);
      end
    end else if (a == A_FCW) begin
      hit = 1'b1;
      rd = {3'h0, s.frequency_control_word};
      if (wr) next_s.frequency_control_word = wd[FCW_W-1:0];
    end else if (a >= A_IOD && a < A_IOD + IOD_SPAN && a[1:0] == 2'h0) begin
      hit = 1'b1;
      if (!oi[2]) begin
        rd = {7'h00, s.iratio[oi[4:3]]};
        if (wr) begin
          next_s.iratio[oi[4:3]] = wd[IOD_W-1:0];
          next_s.icnt[oi[4:3]] = '0;
          next_s.sq[oi[4:3]] = s.sqen[oi[4:3]];
        end
      end else begin
        rd = {16'h0000, s.np[oi[4:3]], 5'h00,
          s.arm[oi[4:3]] | (s.left[oi[4:3]] != '0),
          s.srmode[oi[4:3]], s.sqen[oi[4:3]]};
        if (wr) begin
          next_s.sqen[oi[4:3]] = wd[0];
          next_s.srmode[oi[4:3]] = wd[IOD_SR];
          next_s.np[oi[4:3]] = wd[IOD_NP +: NP_W];
          if ($signed(wd[31:IOD_PH]) > PH_IMAX)
            next_s.iph[oi[4:3]] = IPH_W'(PH_IMAX);
          else if ($signed(wd[31:IOD_PH]) < -PH_IMAX)
            next_s.iph[oi[4:3]] = IPH_W'(-PH_IMAX);
          else if (wd[31:IOD_PH] != '0)
            next_s.iph[oi[4:3]] = wd[31:IOD_PH];
        end
      end
    end else if (a >= A_FOD && a < A_FOD + FOD_SPAN && a[1:0] == 2'h0) begin
      hit = 1'b1;
      unique case (of[3:2])
        2'h0: begin
          rd = {s.rate[of[5:4]], s.amp[of[5:4]], s.ctr[of[5:4]],
            s.sscen[of[5:4]], s.byp[of[5:4]], s.fint[of[5:4]]};
          if (wr) begin
            next_s.fint[of[5:4]] = wd[FI_W-1:0];
            next_s.byp[of[5:4]] = wd[FOD_BYP];
            next_s.sscen[of[5:4]] = wd[FOD_SSC] &&
              (of[5:4] < 2'(SSC_FODS));
            next_s.ctr[of[5:4]] = wd[FOD_CTR];
            next_s.amp[of[5:4]] = wd[FOD_AMP +: AMP_W];
            next_s.rate[of[5:4]] = wd[FOD_RATE +: RATE_W];
          end
        end
        2'h1: begin
          rd = s.tgt[of[5:4]][31:0];
          if (wr) next_s.tgt[of[5:4]][31:0] = wd;
        end
        2'h2: begin
          rd = {s.fph[of[5:4]], 2'h0, s.tgt[of[5:4]][NUM_W-1:32],
            s.s2n[of[5:4]]};
          if (wr) begin
            next_s.s2n[of[5:4]] = wd[S2_W-1:0];
            next_s.tgt[of[5:4]][NUM_W-1:32] = wd[FOD_NHI +: 2];
            if ($signed(wd[31:FOD_PH]) > PH_QMAX)
              next_s.fph[of[5:4]] = FPH_W'(PH_QMAX);
            else if ($signed(wd[31:FOD_PH]) < -PH_QMAX)
              next_s.fph[of[5:4]] = FPH_W'(-PH_QMAX);
            else if (wd[31:FOD_PH] != '0)
              next_s.fph[of[5:4]] = wd[31:FOD_PH];
          end
        end
        2'h3: begin
          rd = s.unit[of[5:4]];
          if (wr) next_s.unit[of[5:4]] = wd;
        end
      endcase
    end else if (a >= A_BANK && a < A_BANK + BANK_SPAN && a[1:0] == 2'h0) begin
      hit = 1'b1;
      rd = {23'h0, ~BANK_OK[ob[4:2]][s.bank[ob[4:2]][2:0]], s.bank[ob[4:2]]};
      if (wr) next_s.bank[ob[4:2]] = wd[7:0];
    end
    next_s.pready = apb.psel & apb.penable & ~s.pready;
    next_s.pslverr = next_s.pready & ~hit;
    next_s.prdata = (next_s.pready & ~apb.pwrite & hit) ? rd : '0;
    next_s.ref_used = ~next_s.dco_en;
    // Divider clocks are formed from the settled next state.
    for (int i = 0; i < N_IOD; i++) begin
      next_s.iclk[i] = (next_s.icnt[i] < (next_s.iratio[i] >> 1)) &&
        !next_s.sq[i] && (!next_s.srmode[i] || next_s.left[i] != '0);
    end
    for (int j = 0; j < N_FOD; j++) begin
      next_s.fclk[j] = next_s.byp[j] ?
        (next_s.cnt1[j] < (next_s.fint[j] >> 1)) : next_s.s2clk[j];
    end
    // Banks route a legal source to a pair or to two single pins.
    for (int k = 0; k < N_BANK; k++) begin
      code = next_s.bank[k][2:0];
      ok = BANK_OK[k][code] & next_s.bank[k][BK_EN];
      unique case (code)
        3'h0: c = (k >= 5) ? s.sy2.clkin1 : next_s.iclk[0];
        3'h1: c = (k >= 5) ? s.sy2.xin : next_s.iclk[1];
        SRC_CLKIN0: c = s.sy2.clkin0;
        default: c = code[2] ? next_s.fclk[2'(code - SRC_FRACTIONAL_DIVIDER_ZERO)] :
          next_s.iclk[code[1:0]];
      endcase
      c = c & ok;
      if (next_s.bank[k][BK_SE]) begin
        next_s.pins.p[k] = c & next_s.bank[k][BK_PEN];
        next_s.pins.n[k] = (c ^ next_s.bank[k][BK_INV]) & ok &
          next_s.bank[k][BK_NEN];
        next_s.pins.oe_p[k] = ok & next_s.bank[k][BK_PEN];
        next_s.pins.oe_n[k] = ok & next_s.bank[k][BK_NEN];
      end else begin
        next_s.pins.p[k] = c;
        next_s.pins.n[k] = ~c & ok;
        next_s.pins.oe_p[k] = ok;
        next_s.pins.oe_n[k] = ok;
      end
    end
  end

  // The whole state freezes while the clock enable is low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= S_RST;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign pins = s.pins;
  assign dco = '{mode: s.dco_en, ref_used: s.ref_used, frequency_control_word: s.frequency_control_word};
  assign fod_delay = s.dly;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ratio_restart_a: assert property (ce && wr && a == A_IOD |=>
    s.icnt[0] == '0 && s.iratio[0] == $past(wd[IOD_W-1:0]))
    else $error("integer ratio write did not restart divider");
  squelch_gap_a: assert property (s.sq[0] |-> !s.iclk[0])
    else $error("squelched integer divider drove a pulse");
  sysref_stop_a: assert property (ce && s.srmode[1] && s.left[1] == '0 &&
    !s.arm[1] ##1 s.left[1] == '0 |-> !s.iclk[1])
    else $error("sysref divider pulsed with no pulses left");
  no_spread_a: assert property (s.st[2] == SS_IDLE && s.t[2] == '0)
    else $error("third fractional divider is spreading");
  amp_limit_a: assert property ($signed(s.t[1]) <= 31'sd30 &&
    $signed(s.t[1]) >= -31'sd30)
    else $error("spread excursion beyond limit");
  spread_stop_a: assert property (s.st[1] != SS_IDLE ##1
    s.st[1] == SS_IDLE |-> s.t[1] == '0 && $past(s.t[1]) == '0)
    else $error("spread stopped away from nominal frequency");
  stage_two_a: assert property (s.s2cnt[0] < 17'h1ffff &&
    (s.s2n[0] < S2_MIN || s.s2cnt[0] < s.s2n[0] || $changed(s.s2n[0])))
    else $error("second stage counter beyond its ratio");
  nco_slew_a: assert property (ce |=>
    (s.num[2] >= $past(s.num[2]) ? s.num[2] - $past(s.num[2]) :
    $past(s.num[2]) - s.num[2]) <= NCO_SLEW)
    else $error("numerator jumped more than one slew step");
  dco_ref_a: assert property (s.dco_en |-> !dco.ref_used)
    else $error("references still in use during dco mode");
  bank_legal_a: assert property (!BANK_OK[3][s.bank[3][2:0]] |->
    !pins.p[3] && !pins.oe_p[3] && !pins.oe_n[3])
    else $error("illegal bank source reached the pins");
endmodule

/* test/odb_rx.sv */
// Receiver model of the clocks that leave the output banks.
// Assumes pins change only at pclk edges and are sampled once per pclk.
`timescale 1ns/1ns
module odb_rx (
  input wire logic pclk,
  input wire logic presetn,
  input wire odb_pkg::odb_pins_t pins,
  output logic [15:0] per [odb_pkg::N_BANK],
  output logic [15:0] cnt [odb_pkg::N_BANK]
);
  import odb_pkg::*;
  logic [N_BANK-1:0] last;
  logic [15:0] age [N_BANK];
  // An undriven pin floats, so its edges are never taken as clock edges.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last <= '0;
      for (int b = 0; b < N_BANK; b++) begin
        per[b] <= 16'h0000;
        cnt[b] <= 16'h0000;
        age[b] <= 16'h0000;
      end
    end else begin
      for (int b = 0; b < N_BANK; b++) begin
        last[b] <= pins.p[b] & pins.oe_p[b];
        age[b] <= age[b] + 16'h0001;
        if (pins.oe_p[b] && pins.p[b] && !last[b]) begin
          per[b] <= age[b] + 16'h0001;
          cnt[b] <= cnt[b] + 16'h0001;
          age[b] <= 16'h0000;
        end
      end
    end
  end
endmodule

/* test/tb_odb_bank.sv */
// Self-checking bench of the output divider bank over APB.
// Assumes one wait state per APB access and pins registered one cycle late.
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
  $display("Error at %0t: got %h want %h", $time, a, b); end end
module tb_odb_bank;
  import odb_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  odb_apb_t apb = '0;
  odb_byp_t byp_in = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  odb_pins_t pins;
  odb_dco_t dco;
  logic [N_FOD-1:0][1:0] fod_delay;
  logic [15:0] per [N_BANK];
  logic [15:0] cnt [N_BANK];
  logic [31:0] lfsr = 32'h408f;
  logic [31:0] rd;
  logic err;
  int err_count = 0;
  int n_tests = 0;
  odb_bank uut (.pclk(pclk), .presetn(presetn), .ce(ce), .apb(apb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .byp_in(byp_in),
    .pins(pins), .dco(dco), .fod_delay(fod_delay));
  odb_rx rx (.pclk(pclk), .presetn(presetn), .pins(pins), .per(per),
    .cnt(cnt));
  // The clock runs at 10 MHz.
  initial begin
    forever #50 pclk = ~pclk;
  end
  // Galois shift register for repeatable random values.
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h0);
  endfunction
  // Bypass clocks follow the random register, which moves only when a test draws a value.
  always @(posedge pclk) begin
    byp_in <= lfsr[2:0];
  end
  task automatic rnd(output logic [31:0] v);
    lfsr = nxt(lfsr);
    v = lfsr;
  endtask
  // One APB transfer; the request stands until pready is seen high, or for at most 50 cycles.
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    apb.penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    apb <= '0;
    if (k >= 50) begin
      err_count++;
      $display("Error at %0t: no pready", $time);
    end
  endtask
  function automatic logic [31:0] bk(input logic [2:0] s, input int se,
    input int pe, input int ne, input int inv);
    return 32'(s) | (32'(se) << BK_SE) | (32'(pe) << BK_PEN) |
      (32'(ne) << BK_NEN) | (32'(inv) << BK_INV) | (32'h1 << BK_EN);
  endfunction
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Watchdog sized well above the fewer than two thousand cycles the tests take.
  initial begin
    #(30000 * 100);
    err_count++;
    test_done();
  end
  initial begin
    logic [31:0] r;
    logic [31:0] n;
    logic [15:0] c0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK(pins, odb_pins_t'(0))
    `CHK(fod_delay, 6'h00)
    xfer(0, A_GLB, 0);
    `CHK(rd, 32'h0)
    $display("Test reset done");
    // Misaligned and unmapped places are refused with zero data.
    xfer(1, 8'h0d, 32'hffffffff);
    `CHK({err, rd}, {1'b1, 32'h0})
    xfer(0, 8'h8c, 0);
    `CHK({err, rd}, {1'b1, 32'h0})
    for (int c = 0; c < 8; c++) begin
      xfer(1, A_BANK, 32'(c));
      xfer(0, A_BANK, 0);
      `CHK(rd[8], ~BANK_OK[0][c])
    end
    $display("Test map done");
    // Integer ratio change shows at once, the last measured period exactly the ratio.
    for (int i = 0; i < 3; i++) begin
      rnd(r);
      r = 32'd2 + r % 32'd7;
      xfer(1, A_IOD, r);
      xfer(1, A_BANK, bk(3'h0, 0, 1, 0, 0));
      repeat (3 * r + 4) @(posedge pclk);
      `CHK(per[0], r[15:0])
    end
    xfer(1, A_IOD + 8'h04, 32'h1);
    xfer(1, A_IOD, 32'h5);
    repeat (20) @(posedge pclk);
    `CHK(per[0], 16'h5)
    $display("Test integer done");
    // Sysref on one masked divider gives exactly the pulse count.
    rnd(n);
    n = 32'd1 + n % 32'd5;
    xfer(1, A_IOD + 8'h08, 32'h3);
    xfer(1, A_IOD + 8'h0c, (n << IOD_NP) | 32'h2);
    xfer(1, A_BANK + 8'h04, bk(3'h1, 0, 1, 0, 0));
    repeat (10) @(posedge pclk);
    c0 = cnt[1];
    xfer(1, A_GLB, (32'h2 << GLB_MASK) | (32'h1 << GLB_GO));
    repeat (3 * n + 20) @(posedge pclk);
    `CHK(cnt[1] - c0, n[15:0])
    xfer(0, A_IOD + 8'h0c, 0);
    `CHK(rd[IOD_BUSY], 1'b0)
    $display("Test sysref done");
    // Fractional divider with and without its second stage.
    xfer(1, A_FOD, 32'h5 | (32'h1 << FOD_BYP));
    xfer(1, A_BANK + 8'h08, bk(SRC_FRACTIONAL_DIVIDER_ZERO, 0, 1, 0, 0));
    repeat (30) @(posedge pclk);
    `CHK(per[2], 16'h5)
    xfer(1, A_FOD + 8'h08, 32'h3);
    xfer(1, A_FOD, 32'h5);
    repeat (100) @(posedge pclk);
    `CHK(per[2], 16'd30)
    // One quarter step forward shows on the edge delay code.
    xfer(1, A_FOD + 8'h08, 32'h3 | (32'h1 << FOD_PH));
    repeat (5) @(posedge pclk);
    `CHK(fod_delay[0], 2'h1)
    // Center spread runs, then stops only after its cycle ends.
    xfer(1, A_FOD + 8'h10, 32'h5 | (32'h1 << FOD_SSC) |
      (32'h1 << FOD_CTR) | (32'h3 << FOD_AMP) | (32'h1 << FOD_RATE));
    repeat (10) @(posedge pclk);
    xfer(0, A_GLB, 0);
    `CHK(rd[GLB_SSCA + 1], 1'b1)
    xfer(1, A_FOD + 8'h10, 32'h5);
    repeat (60) @(posedge pclk);
    xfer(0, A_GLB, 0);
    `CHK(rd[GLB_SSCA + 1], 1'b0)
    // A numerator target far away is walked to gradually.
    xfer(1, A_FOD + 8'h24, 32'h00100000);
    xfer(0, A_FOD + 8'h24, 0);
    `CHK(rd, 32'h00100000)
    repeat (1100) @(posedge pclk);
    xfer(1, A_FOD + 8'h20, 32'h5 | (32'h1 << FOD_SSC));
    xfer(0, A_FOD + 8'h20, 0);
    `CHK(rd[FOD_SSC], 1'b0)
    $display("Test fractional done");
    // Single-ended pair, inverted then in phase, then n pin tristated.
    xfer(1, A_IOD + 8'h10, 32'h3);
    for (int v = 1; v >= 0; v--) begin
      xfer(1, A_BANK + 8'h14, bk(3'h2, 1, 1, 1, v));
      repeat (4) @(posedge pclk);
      for (int t = 0; t < 6; t++) begin
        #10 `CHK(pins.n[5], pins.p[5] ^ v[0])
        @(posedge pclk);
      end
    end
    xfer(1, A_BANK + 8'h14, bk(3'h2, 1, 1, 0, 0));
    repeat (3) @(posedge pclk);
    `CHK(pins.oe_n[5], 1'b0)
    $display("Test pins done");
    // Control word reaches the feedback and references drop out.
    rnd(r);
    xfer(1, A_FCW, r);
    xfer(1, A_GLB, 32'h1);
    repeat (2) @(posedge pclk);
    `CHK(dco.frequency_control_word, r[FCW_W-1:0])
    `CHK({dco.mode, dco.ref_used}, 2'b10)
    $display("Test control word done");
    test_done();
  end
endmodule
